// ### pkg/dqs_dll_cfg.svh
// Build constants for the strobe phase-shift block.
// Assumes inclusion by bare name from the package and design modules.
`ifndef DQS_DLL_CFG_SVH
`define DQS_DLL_CFG_SVH

// ****************************************
// Widths and counts
// ****************************************
`define SET_W 6
`define SET_MAX 6'h3f
`define TAP_W 4
`define CORNERS 4
`define GROUPS 8
`define DATA_W 8
`define LOCK_W 11
`define LOCK_LOWJIT_CYC 1280
`define LOCK_NORMAL_CYC 256

// ****************************************
// Fixed low-frequency shift
// ****************************************
`define SHIFT_FIXED_PS 2500
`define TAP_STEP_PS 100
`define SHIFT_FIXED_CODE (`SHIFT_FIXED_PS / `TAP_STEP_PS)

// ****************************************
// Bank adjacency, two bits per bank, bank 1 lowest
// ****************************************
`define BANK_FIRST_CORNER 16'hfa50
`define BANK_SECOND_CORNER 16'h0fa5
`define SRC_LAST 2'h2

`endif

// ### pkg/dqs_dll_pkg.sv
// Types and code helpers for the strobe phase-shift block.
// Assumes the constants header on the include path.
`include "dqs_dll_cfg.svh"
package dqs_dll_pkg;
  typedef logic [`SET_W-1:0] set_t;

  typedef enum logic [1:0] {
    LOOP_RESET = 2'b00,
    LOOP_LOCKING = 2'b01,
    LOOP_LOCKED = 2'b10
  } loop_state_t;

  typedef struct packed {
    logic [1:0] rst_s;
    logic [1:0] jit_s;
    logic [1:0] sel_a;
    logic [1:0] sel_b;
    logic [2:0] up_a;
    logic [2:0] up_b;
    set_t cnt;
    set_t gray;
    logic [`TAP_W-1:0] tap;
    logic [`LOCK_W-1:0] lock_cnt;
    loop_state_t state;
  } loop_regs_t;

  typedef struct packed {
    set_t [`CORNERS-1:0] g_a;
    set_t [`CORNERS-1:0] g_b;
    logic [`CORNERS-1:0] lk_a;
    logic [`CORNERS-1:0] lk_b;
    set_t [`GROUPS-1:0] dly;
    set_t [`GROUPS-1:0] lvl;
    logic [1:0] fb;
    logic fbd;
    logic [1:0] ck;
    logic [1:0] ckn;
    logic [1:0] dqs;
    logic ck_oe;
    logic phase;
    logic [`DATA_W-1:0] wr_hi;
    logic [`DATA_W-1:0] wr_out;
    logic [`DATA_W-1:0] rd_lo;
    logic [2*`DATA_W-1:0] rd_out;
    logic rd_vld;
  } core_regs_t;

  function automatic set_t bin2gray(input set_t b);
    return b ^ (b >> 1);
  endfunction

  function automatic set_t gray2bin(input set_t g);
    set_t b;
    b[`SET_W-1] = g[`SET_W-1];
    for (int i = `SET_W - 2; i >= 0; i--) begin
      b[i] = b[i+1] ^ g[i];
    end
    return b;
  endfunction
endpackage

// ### pkg/dll_corner_if.sv
// Carries one corner loop's settings toward the core.
// Assumes both signals change on the loop's reference clock.
`timescale 1ns/100ps
`include "dqs_dll_cfg.svh"
interface dll_corner_if;
  dqs_dll_pkg::set_t base_gray;
  logic lock;
  modport loop (output base_gray, output lock);
  modport user (input base_gray, input lock);
endinterface

// ### core/dll_corner_loop.sv
// One corner delay-locked loop on its own reference clock.
// Assumes control levels arrive from the core domain, quasi-static.
`timescale 1ns/100ps
`include "dqs_dll_cfg.svh"
module dll_corner_loop (
  // Reference clock domain
  input wire logic ref_clk,
  input wire logic resetn,
  // Control levels from the core domain
  input wire logic dll_rst,
  input wire logic low_jitter,
  input wire logic [1:0] ref_sel,
  // Comparator indications, one per reference source
  input wire logic [2:0] upndn,
  // Delay chain tap select
  output logic [`TAP_W-1:0] chain_tap,
  // Settings toward the core
  dll_corner_if.loop dll
);
  dqs_dll_pkg::loop_regs_t r_r, r_nxt;
  logic [`LOCK_W-1:0] lock_lim;
  logic up;
  dqs_dll_pkg::set_t step;

  // ****************************************
  // Tracking and lock sequencing
  // ****************************************
  always_comb begin
    r_nxt = r_r;
    lock_lim = r_r.jit_s[1] ? `LOCK_W'(`LOCK_LOWJIT_CYC) : `LOCK_W'(`LOCK_NORMAL_CYC);
    up = (r_r.sel_b > `SRC_LAST) ? r_r.up_b[0] : r_r.up_b[r_r.sel_b];
    r_nxt.rst_s = {r_r.rst_s[0], dll_rst};
    r_nxt.jit_s = {r_r.jit_s[0], low_jitter};
    r_nxt.sel_a = ref_sel;
    r_nxt.sel_b = r_r.sel_a;
    r_nxt.up_a = upndn;
    r_nxt.up_b = r_r.up_a;
    if (up && r_r.cnt != `SET_MAX) begin
      step = r_r.cnt + `SET_W'(1);
    end else if (!up && r_r.cnt != '0) begin
      step = r_r.cnt - `SET_W'(1);
    end else begin
      step = r_r.cnt;
    end
    case (r_r.state)
      dqs_dll_pkg::LOOP_RESET: begin
        r_nxt.cnt = '0;
        r_nxt.lock_cnt = '0;
        r_nxt.state = dqs_dll_pkg::LOOP_LOCKING;
      end
      dqs_dll_pkg::LOOP_LOCKING: begin
        r_nxt.cnt = step;
        r_nxt.lock_cnt = r_r.lock_cnt + `LOCK_W'(1);
        if (r_r.lock_cnt == lock_lim - `LOCK_W'(1)) begin
          r_nxt.state = dqs_dll_pkg::LOOP_LOCKED;
        end
      end
      dqs_dll_pkg::LOOP_LOCKED: begin
        r_nxt.cnt = step;
      end
      default: begin
        r_nxt.state = dqs_dll_pkg::LOOP_RESET;
      end
    endcase
    // Each loop reset restarts the full lock interval
    if (r_r.rst_s[1]) begin
      r_nxt.state = dqs_dll_pkg::LOOP_RESET;
      r_nxt.cnt = '0;
      r_nxt.lock_cnt = '0;
    end
    r_nxt.gray = dqs_dll_pkg::bin2gray(r_nxt.cnt);
    r_nxt.tap = r_nxt.cnt[`SET_W-1:`SET_W-`TAP_W];
  end

  always_ff @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      r_r <= '0;
    end else begin
      r_r <= r_nxt;
    end
  end

  assign chain_tap = r_r.tap;
  assign dll.base_gray = r_r.gray;
  assign dll.lock = (r_r.state == dqs_dll_pkg::LOOP_LOCKED);

  // ****************************************
  // Checks
  // ****************************************
  // A loop reset may jump straight to zero; only tracking steps must be one bit
  a_gray_step: assert property (
    @(posedge ref_clk) disable iff (!resetn)
    !$past(r_r.rst_s[1]) |-> $countones(r_r.gray ^ $past(r_r.gray)) <= 1
  ) else $error("setting changed more than one bit");

  a_lock_time: assert property (
    @(posedge ref_clk) disable iff (!resetn)
    $rose(dll.lock) |-> ($past(r_r.state) == dqs_dll_pkg::LOOP_LOCKING)
      && ($past(r_r.lock_cnt) == $past(lock_lim) - `LOCK_W'(1))
  ) else $error("lock asserted at wrong count");

  a_lock_clear: assert property (
    @(posedge ref_clk) disable iff (!resetn)
    r_r.rst_s[1] |=> !dll.lock ##1 !dll.lock
  ) else $error("lock held through loop reset");

  a_count_step: assert property (
    @(posedge ref_clk) disable iff (!resetn)
    (r_r.state == dqs_dll_pkg::LOOP_LOCKED && !r_r.rst_s[1] && up && r_r.cnt != `SET_MAX)
      |=> r_r.cnt == $past(r_r.cnt) + `SET_W'(1)
  ) else $error("counter did not step up");
endmodule

// ### core/dqs_phase_shift_dll.sv
// Strobe phase-shift top: four corner loops, per-group strobe delay,
// memory clock output registers and full/half-rate conversion.
// Assumes core inputs on mclk; loop inputs and feedback pin are asynchronous.
`timescale 1ns/100ps
`include "dqs_dll_cfg.svh"
module dqs_phase_shift_dll (
  // Core clock and reset
  input wire logic mclk,
  input wire logic resetn,

  // Loop reference clock
  input wire logic ref_clk,

  // Corner loop control
  input wire logic [`CORNERS-1:0] dll_rst,
  input wire logic [`CORNERS-1:0] low_jitter,
  input wire logic [`CORNERS-1:0][1:0] ref_sel,
  input wire logic [`CORNERS-1:0][2:0] upndn,
  input wire logic [`CORNERS-1:0][`SET_W-1:0] offset_a,
  input wire logic [`CORNERS-1:0][`SET_W-1:0] offset_b,

  // Corner loop status
  output logic [`CORNERS-1:0] dll_lock,
  output logic [`CORNERS-1:0][`TAP_W-1:0] chain_tap,

  // Strobe group control
  input wire logic [`GROUPS-1:0] grp_corner_sel,
  input wire logic [`GROUPS-1:0] grp_out_sel,
  input wire logic [`GROUPS-1:0] read_active,
  input wire logic [`GROUPS-1:0] level_en,
  input wire logic low_freq_mode,

  // Strobe group settings
  output logic [`GROUPS-1:0][`SET_W-1:0] strobe_delay,
  output logic [`GROUPS-1:0][`SET_W-1:0] level_delay,

  // Memory clock and write strobe
  input wire logic ck_en,
  input wire logic wr_strobe_en,
  input wire logic strobe_diff,
  output logic ck_rise,
  output logic ck_fall,
  output logic ckn_rise,
  output logic ckn_fall,
  output logic dqs_wr_rise,
  output logic dqs_wr_fall,

  // First memory clock pin feedback
  input wire logic ck0_fb_in,
  output logic ck0_oe,
  output logic ck0_fb_diff,
  output logic ck0_fb_level,

  // Rate conversion
  input wire logic half_rate,
  input wire logic [2*`DATA_W-1:0] wr_half_data,
  output logic wr_take,
  output logic [`DATA_W-1:0] wr_full_data,
  input wire logic [`DATA_W-1:0] rd_full_data,
  output logic [2*`DATA_W-1:0] rd_half_data,
  output logic rd_half_valid
);

  // ****************************************
  // Declarations
  // ****************************************
  localparam logic [2*`GROUPS-1:0] FIRST_CORNER = `BANK_FIRST_CORNER;
  localparam logic [2*`GROUPS-1:0] SECOND_CORNER = `BANK_SECOND_CORNER;
  localparam dqs_dll_pkg::set_t FIXED_GRAY = dqs_dll_pkg::bin2gray(`SET_W'(`SHIFT_FIXED_CODE));

  dqs_dll_pkg::core_regs_t r_r, r_nxt;

  dqs_dll_pkg::set_t [`CORNERS-1:0] base_gray;
  logic [`CORNERS-1:0] base_lock;
  logic [`CORNERS-1:0][`SET_W:0] sum_a;
  logic [`CORNERS-1:0][`SET_W:0] sum_b;
  dqs_dll_pkg::set_t [`CORNERS-1:0] set_a;
  dqs_dll_pkg::set_t [`CORNERS-1:0] set_b;
  dqs_dll_pkg::set_t [`GROUPS-1:0] dly_nxt;
  dqs_dll_pkg::set_t [`GROUPS-1:0] lvl_nxt;

  // ****************************************
  // Corner loops
  // ****************************************
  // Offsets are added after the crossing, so each output
  // still moves by one code step and stays one-bit Gray.
  genvar c;
  generate
    for (c = 0; c < `CORNERS; c++) begin : corner
      dll_corner_if cif ();

      dll_corner_loop loop_u (
        .ref_clk(ref_clk),
        .resetn(resetn),
        .dll_rst(dll_rst[c]),
        .low_jitter(low_jitter[c]),
        .ref_sel(ref_sel[c]),
        .upndn(upndn[c]),
        .chain_tap(chain_tap[c]),
        .dll(cif.loop)
      );

      assign base_gray[c] = cif.base_gray;
      assign base_lock[c] = cif.lock;

      assign sum_a[c] = {1'b0, dqs_dll_pkg::gray2bin(r_r.g_b[c])} + {1'b0, offset_a[c]};
      assign sum_b[c] = {1'b0, dqs_dll_pkg::gray2bin(r_r.g_b[c])} + {1'b0, offset_b[c]};
      assign set_a[c] = dqs_dll_pkg::bin2gray(sum_a[c][`SET_W] ? `SET_MAX : sum_a[c][`SET_W-1:0]);
      assign set_b[c] = dqs_dll_pkg::bin2gray(sum_b[c][`SET_W] ? `SET_MAX : sum_b[c][`SET_W-1:0]);
    end
  endgenerate

  // ****************************************
  // Strobe groups, one per bank
  // ****************************************
  genvar g;
  generate
    for (g = 0; g < `GROUPS; g++) begin : group
      logic [1:0] c_sel;
      dqs_dll_pkg::set_t pick;

      // Both sides of a corner read the same corner setting
      assign c_sel = grp_corner_sel[g] ? SECOND_CORNER[2*g +: 2] : FIRST_CORNER[2*g +: 2];
      assign pick = grp_out_sel[g] ? set_b[c_sel] : set_a[c_sel];

      // Low-frequency shift is not centred; margin covers it
      assign dly_nxt[g] = !read_active[g] ? '0 : (low_freq_mode ? FIXED_GRAY : pick);

      // Single leveling chain per sub-bank, held off until lock
      assign lvl_nxt[g] = (r_r.lk_b[c_sel] && level_en[g]) ? pick : '0;
    end
  endgenerate

  // ****************************************
  // Next state
  // ****************************************
  always_comb begin
    r_nxt = r_r;

    // Two-flop crossings from the reference domain
    r_nxt.g_a = base_gray;
    r_nxt.g_b = r_r.g_a;
    r_nxt.lk_a = base_lock;
    r_nxt.lk_b = r_r.lk_a;

    // Every group loads from one snapshot on one edge
    r_nxt.dly = dly_nxt;
    r_nxt.lvl = lvl_nxt;

    // Same register stage keeps clock and strobe aligned
    r_nxt.ck = ck_en ? 2'h2 : 2'h0;
    r_nxt.ckn = ck_en ? 2'h1 : 2'h0;
    r_nxt.dqs = wr_strobe_en ? 2'h2 : 2'h0;
    r_nxt.ck_oe = ck_en;

    // Feedback input, buffer mode follows strobe type
    r_nxt.fb = {r_r.fb[0], ck0_fb_in};
    r_nxt.fbd = strobe_diff;

    // Full/half-rate conversion
    r_nxt.phase = half_rate ? ~r_r.phase : 1'b0;
    if (!half_rate) begin
      r_nxt.wr_out = wr_half_data[`DATA_W-1:0];
      r_nxt.rd_out = {{`DATA_W{1'b0}}, rd_full_data};
      r_nxt.rd_vld = 1'b1;
    end else if (!r_r.phase) begin
      r_nxt.wr_hi = wr_half_data[2*`DATA_W-1:`DATA_W];
      r_nxt.wr_out = wr_half_data[`DATA_W-1:0];
      r_nxt.rd_lo = rd_full_data;
      r_nxt.rd_vld = 1'b0;
    end else begin
      r_nxt.wr_out = r_r.wr_hi;
      r_nxt.rd_out = {rd_full_data, r_r.rd_lo};
      r_nxt.rd_vld = 1'b1;
    end
  end

  always_ff @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      r_r <= '0;
    end else begin
      r_r <= r_nxt;
    end
  end

  // ****************************************
  // Outputs
  // ****************************************
  assign dll_lock = r_r.lk_b;
  assign strobe_delay = r_r.dly;
  assign level_delay = r_r.lvl;

  assign ck_rise = r_r.ck[1];
  assign ck_fall = r_r.ck[0];
  assign ckn_rise = r_r.ckn[1];
  assign ckn_fall = r_r.ckn[0];
  assign dqs_wr_rise = r_r.dqs[1];
  assign dqs_wr_fall = r_r.dqs[0];

  assign ck0_oe = r_r.ck_oe;
  assign ck0_fb_diff = r_r.fbd;
  assign ck0_fb_level = r_r.fb[1];

  // In half-rate mode both bytes are taken while wr_take is high; the source may change the word while it is low
  assign wr_take = !half_rate || !r_r.phase;
  assign wr_full_data = r_r.wr_out;
  assign rd_half_data = r_r.rd_out;
  assign rd_half_valid = r_r.rd_vld;

  // ****************************************
  // Checks
  // ****************************************
  a_read_only_shift: assert property (
    @(posedge mclk) disable iff (!resetn)
    !read_active[0] |=> strobe_delay[0] == '0
  ) else $error("strobe shifted outside read");

  a_low_freq_fixed: assert property (
    @(posedge mclk) disable iff (!resetn)
    (read_active[2] && low_freq_mode) |=> strobe_delay[2] == FIXED_GRAY
  ) else $error("fixed shift not applied");

  a_groups_together: assert property (
    @(posedge mclk) disable iff (!resetn)
    (grp_corner_sel[0] == grp_corner_sel[1] && grp_out_sel[0] == grp_out_sel[1]
      && read_active[1:0] == 2'h3) |=> strobe_delay[0] == strobe_delay[1]
  ) else $error("groups updated apart");

  a_level_unlocked: assert property (
    @(posedge mclk) disable iff (!resetn)
    !r_r.lk_b[group[0].c_sel] |=> level_delay[0] == '0
  ) else $error("leveling used before lock");

  a_clock_follows: assert property (
    @(posedge mclk) disable iff (!resetn)
    (ck_en && wr_strobe_en) |=> (ck_rise && !ck_fall && !ckn_rise && ckn_fall && dqs_wr_rise)
  ) else $error("memory clock not aligned with strobe");

  a_bypass_path: assert property (
    @(posedge mclk) disable iff (!resetn)
    !half_rate |=> (wr_full_data == $past(wr_half_data[`DATA_W-1:0])) && rd_half_valid
  ) else $error("bypass path wrong");

  a_half_pair: assert property (
    @(posedge mclk) disable iff (!resetn)
    (half_rate && r_r.phase) |=> rd_half_valid
      && (rd_half_data == {$past(rd_full_data), $past(rd_full_data, 2)})
  ) else $error("half-rate read pairing wrong");
endmodule

// ### verif/mem_far_model.sv
// Behavioural memory device on the far side of the strobe block.
// Assumes the core clock and the lock status of the corner that serves it.
`timescale 1ns/100ps
module mem_far_model (
  // Core side
  input wire logic mclk,
  input wire logic resetn,
  input wire logic lock_seen,
  // Memory pins
  input wire logic ck_rise,
  output logic ck0_fb_in,
  output logic [7:0] rd_byte
);
  logic [7:0] next_r;

  // ****************************************
  // Feedback and read data
  // ****************************************
  // Memory clock comes back through the first pin's input buffer
  assign ck0_fb_in = ck_rise;
  // One clock serves data and commands alike
  // No real read data until lock; toggling so nothing passes by chance
  always_ff @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      next_r <= 8'h01;
      rd_byte <= 8'hff;
    end else if (!lock_seen) begin
      rd_byte <= ~rd_byte;
    end else begin
      rd_byte <= next_r;
      next_r <= next_r + 8'h01;
    end
  end
endmodule

// ### verif/dqs_phase_shift_dll_tb.sv
// Self-checking bench for the strobe phase-shift block.
// Assumes the constants header on the include path; inputs change at falling mclk.
`timescale 1ns/100ps
`include "dqs_dll_cfg.svh"
module dqs_phase_shift_dll_tb;
  logic mclk, resetn, ref_clk, low_freq_mode, ck_en, wr_strobe_en, strobe_diff, ck0_fb_in, half_rate;
  logic [3:0] dll_rst, low_jitter, dll_lock;
  logic [3:0][1:0] ref_sel;
  logic [3:0][2:0] upndn;
  logic [3:0][5:0] offset_a, offset_b;
  logic [3:0][3:0] chain_tap;
  logic [7:0] grp_corner_sel, grp_out_sel, read_active, level_en;
  logic [7:0][5:0] strobe_delay, level_delay;
  logic ck_rise, ck_fall, ckn_rise, ckn_fall, dqs_wr_rise, dqs_wr_fall, ck0_oe, ck0_fb_diff, ck0_fb_level;
  logic wr_take, rd_half_valid;
  logic [15:0] wr_half_data, rd_half_data;
  logic [7:0] wr_full_data, rd_full_data;
  logic [7:0] pat_c [5] = '{8'h00, 8'hff, 8'h00, 8'hff, 8'ha5};
  logic [7:0] pat_o [5] = '{8'h00, 8'h00, 8'hff, 8'hff, 8'h3c};
  int err_total, comparisons;

  dqs_phase_shift_dll uut (.mclk, .resetn, .ref_clk, .dll_rst, .low_jitter, .ref_sel, .upndn, .offset_a,
    .offset_b, .dll_lock, .chain_tap, .grp_corner_sel, .grp_out_sel, .read_active, .level_en,
    .low_freq_mode, .strobe_delay, .level_delay, .ck_en, .wr_strobe_en, .strobe_diff, .ck_rise, .ck_fall,
    .ckn_rise, .ckn_fall, .dqs_wr_rise, .dqs_wr_fall, .ck0_fb_in, .ck0_oe, .ck0_fb_diff, .ck0_fb_level,
    .half_rate, .wr_half_data, .wr_take, .wr_full_data, .rd_full_data, .rd_half_data, .rd_half_valid);

  mem_far_model far (.mclk, .resetn, .lock_seen(dll_lock[0]), .ck_rise, .ck0_fb_in, .rd_byte(rd_full_data));

  // ****************************************
  // Clocks, unrelated in phase
  // ****************************************
  initial begin
    mclk = 1'b0;
    forever #50 mclk = ~mclk;
  end
  initial begin
    ref_clk = 1'b0;
    #3.1;
    forever #6 ref_clk = ~ref_clk;
  end

  // ****************************************
  // Helpers
  // ****************************************
  task automatic chk(input string what, input logic [15:0] seen, input logic [15:0] exp);
    comparisons++;
    if (seen !== exp) begin
      err_total++;
      $display("[ERR] %s expected %h seen %h", what, exp, seen);
    end
  endtask

  task automatic cyc(input int n);
    repeat (n) @(negedge mclk);
  endtask

  task automatic report_and_stop;
    $display("Comparisons %0d, mismatches %0d", comparisons, err_total);
    if (err_total == 0 && comparisons > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask

  // Only corner 1 counts up (its pin source says up), so it sits at 63
  function automatic logic [5:0] want(input int g, input logic osel);
    int c;
    logic [6:0] s;
    c = (g / 2 + grp_corner_sel[g]) % 4;
    s = (osel ? offset_b[c] : offset_a[c]) + (c == 1 ? 7'h3f : 7'h00);
    if (s > 7'h3f) s = 7'h3f;
    return s[5:0] ^ (s[5:0] >> 1);
  endfunction

  // One half-rate word out, two full-rate bytes in
  task automatic half_word(input logic [15:0] w);
    logic [7:0] b0, b1;
    int n;
    n = 0;
    while (wr_take !== 1'b1 && n < 4) begin
      @(negedge mclk);
      n++;
    end
    chk("wr_take", wr_take, 1'b1);
    wr_half_data = w;
    b0 = rd_full_data;
    @(negedge mclk);
    chk("wr_full lo", wr_full_data, w[7:0]);
    chk("wr_take held", wr_take, 1'b0);
    b1 = rd_full_data;
    wr_half_data = ~w;
    @(negedge mclk);
    chk("wr_full hi", wr_full_data, w[15:8]);
    chk("rd_half", rd_half_data, {b1, b0});
    chk("rd_valid", rd_half_valid, 1'b1);
  endtask

  // ****************************************
  // Sequence
  // ****************************************
  initial begin
    resetn = 1'b0;
    dll_rst = 4'h0;
    low_jitter = 4'h2;
    ref_sel = {2'h3, 2'h2, 2'h1, 2'h0};
    upndn = {4{3'h2}};
    offset_a = {6'h04, 6'h03, 6'h02, 6'h01};
    offset_b = {6'h3e, 6'h0c, 6'h0b, 6'h0a};
    {grp_corner_sel, grp_out_sel, read_active, level_en} = 32'h0000_0000;
    {low_freq_mode, ck_en, wr_strobe_en, strobe_diff, half_rate} = 5'h00;
    wr_half_data = 16'h0000;
    cyc(5);
    chk("lock in reset", dll_lock, 4'h0);
    chk("take in reset", wr_take, 1'b1);
    resetn = 1'b1;
    cyc(25);
    chk("lock early", dll_lock, 4'h0);
    cyc(11);
    chk("lock normal", dll_lock, 4'hd);
    cyc(109);
    chk("lock low jitter early", dll_lock, 4'hd);
    cyc(15);
    chk("lock all", dll_lock, 4'hf);
    for (int c = 0; c < 4; c++) begin
      chk("chain_tap", chain_tap[c], c == 1 ? 4'hf : 4'h0);
    end
    read_active = 8'hff;
    for (int p = 0; p < 5; p++) begin
      grp_corner_sel = pat_c[p];
      grp_out_sel = pat_o[p];
      cyc(1);
      for (int g = 0; g < 8; g++) begin
        chk("strobe_delay", strobe_delay[g], want(g, grp_out_sel[g]));
      end
    end
    read_active = 8'h0f;
    cyc(1);
    for (int g = 0; g < 8; g++) begin
      chk("strobe_delay rd", strobe_delay[g], g < 4 ? want(g, grp_out_sel[g]) : 6'h00);
    end
    read_active = 8'hff;
    low_freq_mode = 1'b1;
    cyc(1);
    chk("fixed shift", strobe_delay[7], 6'h15);
    chk("level off", level_delay[0], 6'h00);
    low_freq_mode = 1'b0;
    upndn = {4{3'h0}};
    cyc(12);
    chk("tap down", chain_tap[1], 4'h0);
    dll_rst = 4'h1;
    upndn = {4{3'h2}};
    grp_corner_sel = 8'h00;
    level_en = 8'h01;
    cyc(5);
    chk("lock after loop reset", dll_lock, 4'he);
    chk("level held in reset", level_delay[0], 6'h00);
    dll_rst = 4'h0;
    cyc(20);
    chk("relock early", dll_lock, 4'he);
    cyc(16);
    chk("relock", dll_lock, 4'hf);
    chk("tap up", chain_tap[1], 4'hf);
    ck_en = 1'b1;
    wr_strobe_en = 1'b1;
    strobe_diff = 1'b1;
    cyc(1);
    chk("ck pairs", {ck_rise, ck_fall, ckn_rise, ckn_fall, dqs_wr_rise, dqs_wr_fall}, 6'h26);
    chk("level on", level_delay[0], want(0, grp_out_sel[0]));
    chk("ck0_oe", ck0_oe, 1'b1);
    chk("fb diff", ck0_fb_diff, 1'b1);
    cyc(2);
    chk("fb level hi", ck0_fb_level, 1'b1);
    ck_en = 1'b0;
    cyc(4);
    chk("fb level lo", ck0_fb_level, 1'b0);
    wr_half_data = 16'h00a7;
    cyc(1);
    chk("bypass", wr_full_data, 8'ha7);
    half_rate = 1'b1;
    cyc(2);
    half_word(16'h5a3c);
    half_word(16'hc381);
    report_and_stop;
  end

  // Run needs about 24 us; a hang stops well after that
  initial begin
    #200000;
    err_total++;
    report_and_stop;
  end
endmodule
